// File: rtl/rdi_pkg.sv
// constants, types and state codes for the redriver i2c configuration target
// Function
// [RQ1] high address strap level picks address bits 7..3 from a four-entry table
// [RQ2] low address strap level gives address bits 2..1; bit 0 is direction
// [RQ3] start plus matching address with write direction is acknowledged
// [RQ4] one sub-address byte, msb first, follows and is acknowledged
// [RQ5] every following data byte is stored and acknowledged
// [RQ6] register pointer steps by one after each written data byte
// [RQ7] controller ends every write, even sub-address only, with a stop; the bench uses a repeated start instead for even k
// [RQ8] read address is acknowledged, then register bytes are sent msb first
// [RQ9] read starts at 00h, last read plus one, or last written sub-address
// [RQ10] after each sent byte wait for ack or nack; ack sends next byte
// [RQ11] nack releases data line and stays quiet until next start
// [RQ12] successive read bytes come from successive register offsets
// [RQ13] a sub-address only write sets the pointer for the next read
// [RQ14] set and clear fields change only bits written with one
// [RQ15] update fields may be changed by hardware on its own
// [RQ16] general control resets to 01h; bits 7..5 and 3 read zero
// [RQ17] bit 4 chooses strap or register equalization source
// [RQ18] bit 2 is the read-write orientation flip bit, reset zero
// [RQ19] bits 1:0 path control: 00 all off, 01 usb path on
// [RQ20] path 00 powers down; path 01 routes unflipped or flipped by flip bit
package rdi_pkg;
   localparam int DATA_W = 8;
   localparam int LVL_W = 2;
   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] BYTE_BITS = 4'h8;
   // four-level strap codes
   localparam logic [LVL_W-1:0] LVL_0 = 2'h0;
   localparam logic [LVL_W-1:0] LVL_R = 2'h1;
   localparam logic [LVL_W-1:0] LVL_F = 2'h2;
   localparam logic [LVL_W-1:0] LVL_1 = 2'h3;
   // address bits 7..3 per high strap level
   localparam logic [4:0] ADDR_HI_L0 = 5'h11;
   localparam logic [4:0] ADDR_HI_LR = 5'h08;
   localparam logic [4:0] ADDR_HI_LF = 5'h04;
   localparam logic [4:0] ADDR_HI_L1 = 5'h03;
   localparam logic [1:0] STRAP_SETTLE = 2'h3;
   // general control register
   localparam logic [DATA_W-1:0] GC_OFFSET = 8'h0a;
   localparam logic [DATA_W-1:0] GC_RESET = 8'h01;
   localparam logic [DATA_W-1:0] GC_RW_MASK = 8'h17;
   localparam logic [DATA_W-1:0] GC_W1S_MASK = 8'h00;
   localparam logic [DATA_W-1:0] GC_W1C_MASK = 8'h00;
   localparam logic [DATA_W-1:0] GC_UPD_MASK = 8'h00;
   localparam logic [DATA_W-1:0] PTR_RESET = 8'h00;
   localparam int EQSRC_BIT = 4;
   localparam int FLIP_BIT = 2;
   localparam int PATH_LSB = 0;
   localparam int PATH_MSB = 1;
   localparam logic [1:0] PATH_OFF = 2'h0;
   localparam logic [1:0] PATH_USB = 2'h1;
   typedef enum logic [8:0] {
      S_IDLE = 9'h001,
      S_ADDR = 9'h002,
      S_ADDR_ACK = 9'h004,
      S_SUB = 9'h008,
      S_SUB_ACK = 9'h010,
      S_WDATA = 9'h020,
      S_WDATA_ACK = 9'h040,
      S_RDATA = 9'h080,
      S_RACK = 9'h100
   } rdi_state_t;
endpackage

// File: rtl/rdi_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module rdi_sync #(
   parameter int W = 1
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   typedef struct packed {
      logic [W-1:0] s2;
      logic [W-1:0] s1;
   } rdi_sync_st_t;
   rdi_sync_st_t r, n;
   if (W < 1) begin : g_chk
      $error("rdi_sync: W must be at least 1");
   end
   always_comb begin
      n.s1 = i_d;
      n.s2 = r.s1;
   end
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end
   assign o_q = r.s2;
endmodule // rdi_sync

// File: rtl/rdi_regfile.sv
// general control register with per-bit access kinds
`timescale 1ns/10ps
module rdi_regfile (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_wr_en,
   input wire logic [rdi_pkg::DATA_W-1:0] i_wr_addr,
   input wire logic [rdi_pkg::DATA_W-1:0] i_wr_data,
   input wire logic [rdi_pkg::DATA_W-1:0] i_rd_addr,
   input wire logic i_upd_en,
   input wire logic [rdi_pkg::DATA_W-1:0] i_upd_data,
   output logic [rdi_pkg::DATA_W-1:0] o_rd_data,
   output logic [rdi_pkg::DATA_W-1:0] o_gc
);
   import rdi_pkg::*;
   typedef struct packed {
      logic [DATA_W-1:0] gc;
   } rdi_rf_st_t;
   rdi_rf_st_t r, n;
   logic hit;
   logic [DATA_W-1:0] bit_nxt;
   assign hit = i_wr_en && (i_wr_addr == GC_OFFSET);
   for (genvar b = 0; b < DATA_W; b++) begin : g_bit
      always_comb begin
         bit_nxt[b] = r.gc[b];
         if (hit && GC_RW_MASK[b]) begin
            bit_nxt[b] = i_wr_data[b];
         end
         if (hit && GC_W1C_MASK[b] && i_wr_data[b]) begin
            bit_nxt[b] = 1'b0; // RQ14
         end
         if (hit && GC_W1S_MASK[b] && i_wr_data[b]) begin
            bit_nxt[b] = 1'b1; // RQ14
         end
         // hardware update wins over a software write in the same cycle
         if (i_upd_en && GC_UPD_MASK[b]) begin
            bit_nxt[b] = i_upd_data[b]; // RQ15
         end
      end
   end
   always_comb begin
      n.gc = bit_nxt;
   end
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         r.gc <= GC_RESET; // RQ16
      end else begin
         r <= n;
      end
   end
   // reserved bits never leave zero; unmapped offsets read zero
   assign o_rd_data = (i_rd_addr == GC_OFFSET) ? r.gc : '0; // RQ16
   assign o_gc = r.gc;
endmodule // rdi_regfile

// File: rtl/rdi_i2c_target.sv
// i2c configuration target of the redriver switch
`timescale 1ns/10ps
module rdi_i2c_target (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic [rdi_pkg::LVL_W-1:0] i_addr_strap_high,
   input wire logic [rdi_pkg::LVL_W-1:0] i_addr_strap_low,
   input wire logic i_hw_upd_valid,
   input wire logic [rdi_pkg::DATA_W-1:0] i_hw_upd_data,
   output logic o_sda_o,
   output logic o_sda_oe,
   output logic o_eq_source_select,
   output logic o_orientation_flip_bit,
   output logic [1:0] o_path_control_field,
   output logic o_usb_enable,
   output logic o_power_down,
   output logic o_flipped
);
   import rdi_pkg::*;

   // ==========================================================
   // state
   typedef struct packed {
      rdi_state_t st;
      logic scl_d;
      logic sda_d;
      logic [CNT_W-1:0] cnt;
      logic [DATA_W-1:0] sh;
      logic [DATA_W-1:0] ptr;
      logic rw;
      logic [1:0] strap_age;
      logic strap_done;
      logic [6:0] my_addr;
      logic sda_oe;
      logic sda_o;
      logic eq_src;
      logic flip;
      logic [1:0] path;
      logic usb_en;
      logic pd;
      logic flipped;
   } rdi_st_t;
   localparam rdi_st_t RST = '{
      st: S_IDLE, scl_d: 1'b1, sda_d: 1'b1, cnt: '0, sh: '0, ptr: PTR_RESET,
      rw: 1'b0, strap_age: '0, strap_done: 1'b0, my_addr: '0, sda_oe: 1'b0,
      sda_o: 1'b0, eq_src: GC_RESET[EQSRC_BIT], flip: GC_RESET[FLIP_BIT],
      path: GC_RESET[PATH_MSB:PATH_LSB], usb_en: 1'b1, pd: 1'b0, flipped: 1'b0};
   rdi_st_t r, n;

   // ==========================================================
   // pin synchronisers and register file
   logic scl;
   logic sda;
   logic [LVL_W-1:0] strap_hi;
   logic [LVL_W-1:0] strap_lo;
   logic wr_en;
   logic [DATA_W-1:0] rd_data;
   logic [DATA_W-1:0] gc;

   rdi_sync #(.W(2 + 2 * LVL_W)) u_sync (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_d({i_scl, i_sda, i_addr_strap_high, i_addr_strap_low}),
      .o_q({scl, sda, strap_hi, strap_lo})
   );

   rdi_regfile u_regs (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_wr_en(wr_en),
      .i_wr_addr(r.ptr),
      .i_wr_data(r.sh),
      .i_rd_addr(r.ptr),
      .i_upd_en(i_hw_upd_valid),
      .i_upd_data(i_hw_upd_data),
      .o_rd_data(rd_data),
      .o_gc(gc)
   );

   // ==========================================================
   // bus events
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   logic byte_done;
   // edges count only once the synchronisers hold real pin levels
   assign scl_rise = r.strap_done && scl && !r.scl_d;
   assign scl_fall = r.strap_done && !scl && r.scl_d;
   assign start_c = r.strap_done && scl && r.scl_d && r.sda_d && !sda;
   assign stop_c = r.strap_done && scl && r.scl_d && !r.sda_d && sda;
   assign byte_done = scl_fall && (r.cnt == BYTE_BITS);

   function automatic logic [4:0] hi_bits(input logic [LVL_W-1:0] lvl);
      logic [4:0] v;
      v = ADDR_HI_L1;
      unique case (lvl)
         LVL_0: v = ADDR_HI_L0;
         LVL_R: v = ADDR_HI_LR;
         LVL_F: v = ADDR_HI_LF;
         LVL_1: v = ADDR_HI_L1;
      endcase
      return v;
   endfunction

   // ==========================================================
   // next state
   always_comb begin
      n = r;
      wr_en = 1'b0;
      n.scl_d = scl;
      n.sda_d = sda;
      // straps settle through the synchroniser, then are caught once
      if (!r.strap_done) begin
         if (r.strap_age == STRAP_SETTLE) begin
            n.strap_done = 1'b1;
            n.my_addr = {hi_bits(strap_hi), strap_lo}; // RQ1 RQ2
         end else begin
            n.strap_age = r.strap_age + 2'h1;
         end
      end
      unique case (r.st)
         S_IDLE: begin
         end
         S_ADDR, S_SUB, S_WDATA: begin
            if (scl_rise) begin
               n.sh = {r.sh[DATA_W-2:0], sda};
               n.cnt = r.cnt + 4'h1;
            end else if (byte_done) begin
               n.cnt = '0;
               if (r.st == S_ADDR) begin
                  if (r.strap_done && (r.sh[DATA_W-1:1] == r.my_addr)) begin
                     n.rw = r.sh[0];
                     n.sda_oe = 1'b1; // RQ3 RQ8
                     n.st = S_ADDR_ACK;
                  end else begin
                     n.st = S_IDLE;
                  end
               end else if (r.st == S_SUB) begin
                  n.ptr = r.sh; // RQ4 RQ13
                  n.sda_oe = 1'b1; // RQ4
                  n.st = S_SUB_ACK;
               end else begin
                  wr_en = 1'b1; // RQ5
                  n.ptr = r.ptr + 8'h01; // RQ6
                  n.sda_oe = 1'b1; // RQ5
                  n.st = S_WDATA_ACK;
               end
            end
         end
         S_ADDR_ACK: begin
            if (scl_fall) begin
               n.sda_oe = 1'b0;
               if (r.rw) begin
                  // pointer holds 00h, last read plus one, written sub-address or last written data offset plus one
                  n.sh = rd_data; // RQ9 RQ8
                  n.sda_oe = !rd_data[DATA_W-1]; // RQ8
                  n.ptr = r.ptr + 8'h01; // RQ12
                  n.st = S_RDATA;
               end else begin
                  n.st = S_SUB;
               end
            end
         end
         S_SUB_ACK, S_WDATA_ACK: begin
            if (scl_fall) begin
               n.sda_oe = 1'b0;
               n.st = S_WDATA;
            end
         end
         S_RDATA: begin
            if (scl_rise) begin
               n.cnt = r.cnt + 4'h1;
            end else if (byte_done) begin
               n.sda_oe = 1'b0; // RQ10
               n.cnt = '0;
               n.st = S_RACK;
            end else if (scl_fall) begin
               n.sh = {r.sh[DATA_W-2:0], 1'b0};
               n.sda_oe = !r.sh[DATA_W-2];
            end
         end
         S_RACK: begin
            if (scl_rise && sda) begin
               n.st = S_IDLE; // RQ11
            end else if (scl_fall) begin
               n.sh = rd_data; // RQ10 RQ12
               n.sda_oe = !rd_data[DATA_W-1];
               n.ptr = r.ptr + 8'h01; // RQ12
               n.st = S_RDATA;
            end
         end
      endcase
      if (start_c) begin
         n.st = S_ADDR;
         n.cnt = '0;
         n.sda_oe = 1'b0;
      end else if (stop_c) begin
         n.st = S_IDLE;
         n.sda_oe = 1'b0;
      end
      n.sda_o = 1'b0;
      // control outputs follow the general control register
      n.eq_src = gc[EQSRC_BIT]; // RQ17
      n.flip = gc[FLIP_BIT]; // RQ18
      n.path = gc[PATH_MSB:PATH_LSB]; // RQ19
      n.usb_en = (gc[PATH_MSB:PATH_LSB] == PATH_USB); // RQ19
      n.pd = (gc[PATH_MSB:PATH_LSB] != PATH_USB); // RQ20
      n.flipped = (gc[PATH_MSB:PATH_LSB] == PATH_USB) && gc[FLIP_BIT]; // RQ20
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         r <= RST;
      end else begin
         r <= n;
      end
   end

   assign o_sda_o = r.sda_o;
   assign o_sda_oe = r.sda_oe;
   assign o_eq_source_select = r.eq_src;
   assign o_orientation_flip_bit = r.flip;
   assign o_path_control_field = r.path;
   assign o_usb_enable = r.usb_en;
   assign o_power_down = r.pd;
   assign o_flipped = r.flipped;

   // ==========================================================
   // assertions
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);

   a_addr_match_ack: assert property ( // RQ3
      (r.st == S_ADDR) && byte_done && !start_c && !stop_c && r.strap_done
      && (r.sh[DATA_W-1:1] == r.my_addr) |=> (r.st == S_ADDR_ACK) && o_sda_oe)
      else $error("matching address not acknowledged");
   a_sub_ptr_load: assert property ( // RQ4
      (r.st == S_SUB) && byte_done && !start_c && !stop_c
      |=> (r.ptr == $past(r.sh)) && o_sda_oe && (r.st == S_SUB_ACK))
      else $error("sub-address not loaded or not acknowledged");
   a_wdata_ack: assert property ( // RQ5
      (r.st == S_WDATA) && byte_done && !start_c && !stop_c
      |-> wr_en ##1 o_sda_oe)
      else $error("data byte not stored and acknowledged");
   a_wptr_step: assert property ( // RQ6
      wr_en |=> r.ptr == $past(r.ptr) + 8'h01)
      else $error("write pointer did not advance");
   a_read_msb: assert property ( // RQ8
      (r.st == S_ADDR_ACK) && scl_fall && r.rw && !start_c && !stop_c
      |=> (o_sda_oe == !$past(rd_data[DATA_W-1])) && (r.st == S_RDATA))
      else $error("first read bit wrong");
   a_nack_release: assert property ( // RQ11
      (r.st == S_RACK) && scl_rise && sda && !start_c
      |=> !o_sda_oe && (r.st == S_IDLE) ##1 !o_sda_oe)
      else $error("line not released after nack");
   a_ack_next_byte: assert property ( // RQ10
      (r.st == S_RACK) && scl_fall && !start_c && !stop_c
      |=> (r.st == S_RDATA) && (r.sh == $past(rd_data)))
      else $error("next byte not sent after ack");
   a_rptr_step: assert property ( // RQ12
      (r.st == S_RDATA) && $changed(r.ptr) |-> r.ptr == $past(r.ptr) + 8'h01)
      else $error("read pointer step wrong");
   a_gc_reserved: assert property ( // RQ16
      (gc[7:5] == 3'h0) && !gc[3])
      else $error("reserved control bits not zero");
   a_path_power: assert property ( // RQ20
      ##1 o_power_down == ($past(gc[PATH_MSB:PATH_LSB]) != PATH_USB)
      && o_flipped == (($past(gc[PATH_MSB:PATH_LSB]) == PATH_USB) && $past(gc[FLIP_BIT])))
      else $error("power down or routing mismatch");
   a_eq_source: assert property ( // RQ17
      ##1 o_eq_source_select == $past(gc[EQSRC_BIT]))
      else $error("equalization source select mismatch");

   // ==========================================================
   // address and framing checks
   a_addr_refused: assert property ( // RQ3
      (r.st == S_ADDR) && byte_done && !start_c && !stop_c
      && !(r.strap_done && (r.sh[DATA_W-1:1] == r.my_addr))
      |=> (r.st == S_IDLE) && !o_sda_oe)
      else $error("unmatched address not ignored");
   a_strap_addr: assert property ( // RQ1 RQ2
      $rose(r.strap_done)
      |-> r.my_addr == {hi_bits($past(strap_hi)), $past(strap_lo)})
      else $error("target address not taken from straps");
   a_start_addr: assert property ( // RQ3 RQ8
      start_c |=> (r.st == S_ADDR) && (r.cnt == '0) && !o_sda_oe)
      else $error("start not followed by address phase");
   a_stop_keep: assert property ( // RQ13
      stop_c |=> (r.st == S_IDLE) && !o_sda_oe && (r.ptr == $past(r.ptr)))
      else $error("stop lost pointer or line");
   a_idle_quiet: assert property ( // RQ11
      (r.st == S_IDLE) && !start_c |=> !o_sda_oe && $stable(r.ptr))
      else $error("idle target drove line or moved pointer");
   a_cnt_range: assert property ( // RQ4
      r.cnt <= BYTE_BITS)
      else $error("bit counter overran a byte");
   a_sub_shift: assert property ( // RQ4
      (r.st == S_SUB) && scl_rise
      |=> (r.sh == {$past(r.sh[DATA_W-2:0]), $past(sda)}) && (r.cnt == $past(r.cnt) + 4'h1))
      else $error("sub-address bit not shifted in");

   // ==========================================================
   // acknowledge, read data, control write and output checks
   a_ack_stands: assert property ( // RQ3 RQ4 RQ5
      ((r.st == S_ADDR_ACK) || (r.st == S_SUB_ACK) || (r.st == S_WDATA_ACK))
      && !scl_fall && !start_c && !stop_c |=> o_sda_oe)
      else $error("acknowledge released early");
   a_ack_release: assert property ( // RQ5
      ((r.st == S_SUB_ACK) || (r.st == S_WDATA_ACK)) && scl_fall
      |=> !o_sda_oe && (r.st == S_WDATA))
      else $error("acknowledge not released after ninth clock");
   a_addr_to_sub: assert property ( // RQ3 RQ4
      (r.st == S_ADDR_ACK) && scl_fall && !r.rw |=> !o_sda_oe && (r.st == S_SUB))
      else $error("write address not followed by sub-address phase");
   a_gc_write: assert property ( // RQ5
      wr_en && (r.ptr == GC_OFFSET) && !i_hw_upd_valid
      |=> (gc & GC_RW_MASK) == ($past(r.sh) & GC_RW_MASK))
      else $error("control byte not stored");
   a_read_load: assert property ( // RQ9
      (r.st == S_ADDR_ACK) && scl_fall && r.rw
      |=> (r.sh == $past(rd_data)) && (r.ptr == $past(r.ptr) + 8'h01))
      else $error("first read byte not loaded from pointer");
   a_read_shift: assert property ( // RQ8
      (r.st == S_RDATA) && scl_fall && (r.cnt != BYTE_BITS)
      |=> o_sda_oe == !$past(r.sh[DATA_W-2]))
      else $error("read bit not shifted out msb first");
   a_byte_release: assert property ( // RQ10
      (r.st == S_RDATA) && byte_done |=> !o_sda_oe && (r.st == S_RACK))
      else $error("line not released for controller acknowledge");
   a_rack_quiet: assert property ( // RQ10
      (r.st == S_RACK) && !scl_fall |=> !o_sda_oe)
      else $error("target drove line during acknowledge slot");
   a_rack_ptr: assert property ( // RQ12
      (r.st == S_RACK) && scl_fall |=> r.ptr == $past(r.ptr) + 8'h01)
      else $error("pointer not stepped for next read byte");
   a_out_fields: assert property ( // RQ18 RQ19
      ##1 (o_orientation_flip_bit == $past(gc[FLIP_BIT]))
      && (o_path_control_field == $past(gc[PATH_MSB:PATH_LSB]))
      && (o_usb_enable == ($past(gc[PATH_MSB:PATH_LSB]) == PATH_USB)))
      else $error("flip or path outputs mismatch");

   // ==========================================================
   // scenario covers
   c_write_byte: cover property (wr_en);
   c_read_more: cover property ((r.st == S_RACK) && scl_fall);
   c_read_nack: cover property ((r.st == S_RACK) && scl_rise && sda);
   c_addr_refused: cover property ((r.st == S_ADDR) && byte_done ##1 (r.st == S_IDLE));
   c_repeated_start: cover property ((r.st == S_WDATA) && start_c);
endmodule // rdi_i2c_target

// File: tb/rdi_ctrl_model.sv
// behavioural i2c bus controller that faces the configuration target
`timescale 1ns/10ps
module rdi_ctrl_model (
   input wire logic i_clk,
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_low,
   output logic [8:0] o_res,
   output logic o_res_tgl
);
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
      o_res = 9'h000;
      o_res_tgl = 1'b0;
   end
   // ==========================================
   // bus phases, each leaves scl low except stop
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   // start or repeated start
   task automatic start();
      o_sda_low <= 1'b0;
      tick(4);
      o_scl <= 1'b1;
      tick(6);
      o_sda_low <= 1'b1;
      tick(6);
      o_scl <= 1'b0;
      tick(4);
   endtask
   task automatic stop();
      o_sda_low <= 1'b1;
      tick(4);
      o_scl <= 1'b1;
      tick(6);
      o_sda_low <= 1'b0;
      tick(6);
   endtask
   // drive while low, sample at end of high
   task automatic slot(input logic b, output logic s);
      o_sda_low <= ~b;
      tick(4);
      o_scl <= 1'b1;
      tick(6);
      s = i_sda;
      o_scl <= 1'b0;
      tick(4);
   endtask
   task automatic send(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         slot(d[i], s);
      end
      slot(1'b1, ack);
      o_res <= {1'b1, 7'h00, ack};
      o_res_tgl <= ~o_res_tgl;
   endtask
   task automatic recv(input logic more);
      logic [7:0] d;
      logic s;
      for (int i = 7; i >= 0; i--) begin
         slot(1'b1, d[i]);
      end
      slot(~more, s);
      o_res <= {1'b0, d};
      o_res_tgl <= ~o_res_tgl;
   endtask
endmodule // rdi_ctrl_model

// File: tb/tb_redriver_i2c_config_target.sv
// self-checking bench for the redriver i2c configuration target
`timescale 1ns/10ps
module tb_redriver_i2c_config_target;
   import rdi_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic [1:0] strap_hi = 2'h0;
   logic [1:0] strap_lo = 2'h0;
   logic upd_v = 1'b0;
   logic [7:0] upd_d = 8'h00;
   logic scl, sda_low, sda_o, sda_oe, eq, flip, usb_en, pd, flipped, res_tgl;
   logic [1:0] path;
   logic [8:0] res;
   logic [8:0] exp_q[$];
   logic [6:0] dev_addr;
   logic [4:0] hi_tab [4] = '{5'h11, 5'h08, 5'h04, 5'h03};
   int fail_count = 0;
   int cmp_count = 0;
   // open drain wire with pull-up
   wire sda = ~(sda_low | (sda_oe & ~sda_o));

   always #20 i_clk = ~i_clk;

   rdi_i2c_target uut (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_scl(scl),
      .i_sda(sda),
      .i_addr_strap_high(strap_hi),
      .i_addr_strap_low(strap_lo),
      .i_hw_upd_valid(upd_v),
      .i_hw_upd_data(upd_d),
      .o_sda_o(sda_o),
      .o_sda_oe(sda_oe),
      .o_eq_source_select(eq),
      .o_orientation_flip_bit(flip),
      .o_path_control_field(path),
      .o_usb_enable(usb_en),
      .o_power_down(pd),
      .o_flipped(flipped)
   );
   rdi_ctrl_model ctrl (
      .i_clk(i_clk),
      .i_sda(sda),
      .o_scl(scl),
      .o_sda_low(sda_low),
      .o_res(res),
      .o_res_tgl(res_tgl)
   );
   // ==========================================
   // comparison and closing
   task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run();
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   always @(res_tgl) begin
      if ($time > 0) begin
         check("bus result", res, exp_q.size() > 0 ? exp_q.pop_front() : 9'hxxx);
      end
   end
   // ==========================================
   // bus helpers, expectations queued first
   task automatic wr(input logic [7:0] b, input logic ack_exp);
      logic a;
      exp_q.push_back({1'b1, 7'h00, ack_exp});
      ctrl.send(b, a);
   endtask
   task automatic rd(input logic [7:0] exp, input logic more);
      exp_q.push_back({1'b0, exp});
      ctrl.recv(more);
   endtask
   task automatic do_reset();
      i_rst_n <= 1'b0;
      repeat (12) @(posedge i_clk);
      i_rst_n <= 1'b1;
      repeat (12) @(posedge i_clk);
   endtask
   task automatic chk_out(input logic [7:0] gc);
      logic [8:0] e;
      e = {2'h0, gc[4], gc[2], gc[1:0], gc[1:0] == 2'h1, gc[1:0] != 2'h1, gc[1:0] == 2'h1 && gc[2]};
      repeat (4) @(posedge i_clk);
      check("ctl out", {2'h0, eq, flip, path, usb_en, pd, flipped}, e);
   endtask
   // ==========================================
   // scenarios
   initial begin
      logic [7:0] d;
      void'($urandom(35));
      // every strap pair: wrong address refused, right one read from 00h
      for (int i = 0; i < 16; i++) begin
         strap_hi <= i[3:2];
         strap_lo <= i[1:0];
         do_reset();
         dev_addr = {hi_tab[i[3:2]], i[1:0]};
         chk_out(8'h01);
         ctrl.start();
         wr({dev_addr ^ (7'h01 << (i % 7)), 1'b0}, 1'b1);
         ctrl.stop();
         ctrl.start();
         wr({dev_addr, 1'b1}, 1'b0);
         rd(8'h00, 1'b0);
         ctrl.stop();
      end
      // no sub-address: resume at last read plus one, through 0ah
      ctrl.start();
      wr({dev_addr, 1'b1}, 1'b0);
      for (int j = 1; j <= 10; j++) begin
         rd(j == 10 ? 8'h01 : 8'h00, j < 10);
      end
      repeat (6) begin
         @(posedge i_clk);
         check("sda release", {8'h00, sda_oe}, 9'h000);
      end
      ctrl.stop();
      ctrl.start();
      wr({dev_addr, 1'b1}, 1'b0);
      rd(8'h00, 1'b0);
      ctrl.stop();
      // every flip and path code, reserved bits set at random
      for (int k = 0; k < 8; k++) begin
         d = (8'($urandom()) & 8'hf8) | 8'(k[2:0]);
         ctrl.start();
         wr({dev_addr, 1'b0}, 1'b0);
         wr(8'h09, 1'b0);
         wr(8'($urandom()), 1'b0);
         wr(d, 1'b0);
         ctrl.stop();
         upd_d <= 8'($urandom());
         upd_v <= 1'b1;
         @(posedge i_clk);
         upd_v <= 1'b0;
         chk_out(d & 8'h17);
         ctrl.start();
         wr({dev_addr, 1'b0}, 1'b0);
         wr(8'h0a, 1'b0);
         if (k[0]) ctrl.stop();
         ctrl.start();
         wr({dev_addr, 1'b1}, 1'b0);
         rd(d & 8'h17, 1'b0);
         ctrl.stop();
      end
      repeat (10) @(posedge i_clk);
      check("pending results", 9'(exp_q.size()), 9'h000);
      complete_run();
   end
   initial begin
      repeat (40000) @(posedge i_clk);
      fail_count++;
      complete_run();
   end
endmodule // tb_redriver_i2c_config_target
